// >>> nvsq_defines.svh
// constants for the nvsram soft sequence host controller
`ifndef NVSQ_DEFINES_SVH
`define NVSQ_DEFINES_SVH
`define NVSQ_ADDR_W 19
`define NVSQ_DATA_W 16
`define NVSQ_SEQ_A1 19'h04e38
`define NVSQ_SEQ_A2 19'h0b1c7
`define NVSQ_SEQ_A3 19'h083e0
`define NVSQ_SEQ_A4 19'h07c1f
`define NVSQ_SEQ_A5 19'h0703f
`define NVSQ_CMD_ASDIS 19'h08b45
`define NVSQ_CMD_ASEN 19'h04b46
`define NVSQ_CMD_STORE 19'h08fc0
`define NVSQ_CMD_RECALL 19'h04c63
`define NVSQ_SEQ_LEN 3'h6
// access phase timing in ref_clk cycles (40 ns each)
`define NVSQ_T_SETUP_NS 40
`define NVSQ_T_ACT_NS 80
`define NVSQ_T_REC_NS 40
`define NVSQ_CYC_NS 40
`define NVSQ_SETUP_CYC (8'((`NVSQ_T_SETUP_NS + `NVSQ_CYC_NS - 1) / `NVSQ_CYC_NS))
`define NVSQ_ACT_CYC (8'((`NVSQ_T_ACT_NS + `NVSQ_CYC_NS - 1) / `NVSQ_CYC_NS))
`define NVSQ_REC_CYC (8'((`NVSQ_T_REC_NS + `NVSQ_CYC_NS - 1) / `NVSQ_CYC_NS))
// read data reaches the logic two flops after the pins
`define NVSQ_SYNC_CYC 8'h02
// busy needs device latency plus two sync flops before it shows
`define NVSQ_BUSY_WAIT_CYC 8'h04
`endif

// >>> nvsq_pkg.sv
// types for the nvsram soft sequence host controller
`include "nvsq_defines.svh"
package nvsq_pkg;
    typedef enum logic [2:0] {
        NVSQ_OP_READ,
        NVSQ_OP_WRITE,
        NVSQ_OP_STORE,
        NVSQ_OP_RECALL,
        NVSQ_OP_AS_DIS,
        NVSQ_OP_AS_EN
    } nvsq_op_e;
    typedef struct packed {
        nvsq_op_e op;
        logic [`NVSQ_ADDR_W-1:0] addr;
        logic [`NVSQ_DATA_W-1:0] wdata;
        logic [1:0] byte_en;
    } nvsq_req_s;
    typedef struct packed {
        logic chip_select_n;
        logic write_enable_n;
        logic output_enable_n;
        logic upper_byte_enable_n;
        logic lower_byte_enable_n;
    } nvsq_ctl_s;
endpackage : nvsq_pkg

// >>> nvsq_host.sv
// host controller issuing accesses and soft command sequences to an nvsram
`timescale 1ns/1ps
`include "nvsq_defines.svh"
// Operation
// - host issues six sequence addresses strictly in listed order, consecutively.
// - write_enable_n stays high during all six accesses of a sequence.
// - accesses one to three read 0x4e38, 0xb1c7, 0x83e0.
// - accesses four and five read 0x7c1f and 0x703f.
// - enable and disable sequences are chip-select timed reads.
// - after changing automatic save, host issues a manual store; this controller returns to idle and leaves that store to the user.
// - any intervening access aborts a sequence.
module nvsq_host
    import nvsq_pkg::*;
(
    input wire logic ref_clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire nvsq_req_s req, // request word
    input wire logic req_valid, // request offered
    output logic req_ready, // controller idle
    output logic [`NVSQ_DATA_W-1:0] rdata, // read data
    output logic rdata_valid, // one-cycle read data pulse
    output logic done, // one-cycle completion pulse
    output logic autosave_follow, // host copy of autosave setting
    output logic [`NVSQ_ADDR_W-1:0] mem_addr, // address pins
    output nvsq_ctl_s mem_ctl, // strobes, all active low
    output logic [`NVSQ_DATA_W-1:0] dq_out, // data to pins
    output logic dq_oe, // drive data pins
    input wire logic [`NVSQ_DATA_W-1:0] dq_in, // data from pins
    input wire logic store_busy_n_in, // busy pin level
    output logic store_busy_n_out, // busy pin drive value
    output logic store_busy_n_oe // busy pin drive enable
);

    typedef enum logic [2:0] {
        NVSQ_IDLE,
        NVSQ_SETUP,
        NVSQ_ACTIVE,
        NVSQ_RECOVER,
        NVSQ_WAIT_BUSY
    } nvsq_state_e;

    ////////////////////////////////////////////////////////////////////
    // sequence address lookup, step 0..5
    function automatic logic [`NVSQ_ADDR_W-1:0] seq_addr(input logic [2:0] step, input nvsq_op_e op);
        logic [`NVSQ_ADDR_W-1:0] a;
        a = `NVSQ_SEQ_A1;
        unique case (step)
            3'h0: a = `NVSQ_SEQ_A1;
            3'h1: a = `NVSQ_SEQ_A2;
            3'h2: a = `NVSQ_SEQ_A3;
            3'h3: a = `NVSQ_SEQ_A4;
            3'h4: a = `NVSQ_SEQ_A5;
            default: begin
                unique case (op)
                    NVSQ_OP_STORE: a = `NVSQ_CMD_STORE;
                    NVSQ_OP_RECALL: a = `NVSQ_CMD_RECALL;
                    NVSQ_OP_AS_DIS: a = `NVSQ_CMD_ASDIS;
                    default: a = `NVSQ_CMD_ASEN;
                endcase
            end
        endcase
        return a;
    endfunction : seq_addr

    function automatic logic is_seq(input nvsq_op_e op);
        return op != NVSQ_OP_READ && op != NVSQ_OP_WRITE;
    endfunction : is_seq

    ////////////////////////////////////////////////////////////////////
    nvsq_state_e state;
    nvsq_req_s cur;
    logic [2:0] step;
    logic [7:0] cnt;
    logic busy_s1, busy_s2;
    logic [`NVSQ_DATA_W-1:0] dq_s1, dq_s2;

    // pin synchronisers; first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        busy_s1 <= store_busy_n_in;
        busy_s2 <= busy_s1;
        dq_s1 <= dq_in;
        dq_s2 <= dq_s1;
    end

    // main access sequencer
    // six addresses issued back to back with no other access between
    // requests are refused mid-sequence so nothing intervenes
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= NVSQ_IDLE;
            cur <= '0;
            step <= 3'h0;
            cnt <= 8'h00;
        end else begin
            unique case (state)
                NVSQ_IDLE: begin
                    // req_ready already folds in the synced busy level
                    if (req_valid && req_ready) begin
                        cur <= req;
                        step <= 3'h0;
                        cnt <= `NVSQ_SETUP_CYC;
                        state <= NVSQ_SETUP;
                    end
                end
                NVSQ_SETUP: begin
                    if (cnt == 8'h01) begin
                        cnt <= `NVSQ_ACT_CYC;
                        state <= NVSQ_ACTIVE;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                NVSQ_ACTIVE: begin
                    if (cnt == 8'h01) begin
                        cnt <= `NVSQ_REC_CYC;
                        state <= NVSQ_RECOVER;
                    end else begin
                        cnt <= cnt - 8'h01;
                    end
                end
                NVSQ_RECOVER: begin
                    if (cnt != 8'h01) begin
                        cnt <= cnt - 8'h01;
                    end else if (is_seq(cur.op) && step != `NVSQ_SEQ_LEN - 3'h1) begin
                        step <= step + 3'h1;
                        cnt <= `NVSQ_SETUP_CYC;
                        state <= NVSQ_SETUP;
                    end else if (cur.op == NVSQ_OP_READ) begin
                        // read data still travels the pin synchroniser
                        cnt <= `NVSQ_SYNC_CYC;
                        state <= NVSQ_WAIT_BUSY;
                    end else if (cur.op == NVSQ_OP_STORE || cur.op == NVSQ_OP_RECALL) begin
                        // hold off until the device releases busy
                        cnt <= `NVSQ_BUSY_WAIT_CYC;
                        state <= NVSQ_WAIT_BUSY;
                    end else begin
                        state <= NVSQ_IDLE;
                    end
                end
                NVSQ_WAIT_BUSY: begin
                    // sample after sync delay; busy may show a few cycles late
                    if (busy_s2 && cnt == 8'h00) begin
                        state <= NVSQ_IDLE;
                    end else if (cnt != 8'h00) begin
                        cnt <= cnt - 8'h01;
                    end
                end
                default: state <= NVSQ_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // pin drive, all registered
    // write_enable_n low only for plain writes, never in a sequence
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            mem_addr <= '0;
            mem_ctl <= '1;
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else begin
            mem_addr <= is_seq(cur.op) ? seq_addr(step, cur.op) : cur.addr;
            mem_ctl.chip_select_n <= !(state == NVSQ_ACTIVE);
            mem_ctl.write_enable_n <= !(state == NVSQ_ACTIVE && cur.op == NVSQ_OP_WRITE);
            mem_ctl.output_enable_n <= !(state == NVSQ_ACTIVE && cur.op != NVSQ_OP_WRITE);
            mem_ctl.upper_byte_enable_n <= !(state == NVSQ_ACTIVE && (is_seq(cur.op) || cur.byte_en[1]));
            mem_ctl.lower_byte_enable_n <= !(state == NVSQ_ACTIVE && (is_seq(cur.op) || cur.byte_en[0]));
            dq_out <= cur.wdata;
            dq_oe <= (state == NVSQ_SETUP || state == NVSQ_ACTIVE) && cur.op == NVSQ_OP_WRITE;
        end
    end

    // answers to the user side
    // host copy follows the command; user must issue a store after
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            req_ready <= 1'b0;
            rdata <= '0;
            rdata_valid <= 1'b0;
            done <= 1'b0;
            autosave_follow <= 1'b1;
        end else begin
            // low on the take edge so one request is never taken twice
            req_ready <= state == NVSQ_IDLE && busy_s2 && !(req_valid && req_ready);
            rdata_valid <= state == NVSQ_WAIT_BUSY && cnt == 8'h01 && cur.op == NVSQ_OP_READ;
            if (state == NVSQ_WAIT_BUSY && cnt == 8'h01 && cur.op == NVSQ_OP_READ) begin
                rdata <= dq_s2;
            end
            done <= (state == NVSQ_RECOVER && cnt == 8'h01 && !(is_seq(cur.op) && step != `NVSQ_SEQ_LEN - 3'h1)
                     && cur.op != NVSQ_OP_STORE && cur.op != NVSQ_OP_RECALL && cur.op != NVSQ_OP_READ)
                    || (state == NVSQ_WAIT_BUSY && busy_s2 && cnt == 8'h00);
            if (state == NVSQ_RECOVER && cnt == 8'h01 && step == `NVSQ_SEQ_LEN - 3'h1) begin
                if (cur.op == NVSQ_OP_AS_DIS) autosave_follow <= 1'b0;
                if (cur.op == NVSQ_OP_AS_EN) autosave_follow <= 1'b1;
            end
        end
    end

    // host never pulls the busy pin; it only watches it
    always_ff @(posedge ref_clk) begin
        store_busy_n_out <= 1'b1;
        store_busy_n_oe <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    a_seq_we_high: assert property (@(posedge ref_clk) disable iff (reset)
        is_seq(cur.op) && state != NVSQ_IDLE |=> mem_ctl.write_enable_n) else $error("we low in sequence");
    a_seq_first_addr: assert property (@(posedge ref_clk) disable iff (reset)
        state == NVSQ_ACTIVE && is_seq(cur.op) && step == 3'h0 |=> mem_addr == `NVSQ_SEQ_A1) else $error("bad step one");
    a_seq_fifth_addr: assert property (@(posedge ref_clk) disable iff (reset)
        state == NVSQ_ACTIVE && is_seq(cur.op) && step == 3'h4 |=> mem_addr == `NVSQ_SEQ_A5) else $error("bad step five");
    a_store_last_addr: assert property (@(posedge ref_clk) disable iff (reset)
        state == NVSQ_ACTIVE && cur.op == NVSQ_OP_STORE && step == 3'h5 |=> mem_addr == `NVSQ_CMD_STORE) else $error("bad store");
    a_recall_last_addr: assert property (@(posedge ref_clk) disable iff (reset)
        state == NVSQ_ACTIVE && cur.op == NVSQ_OP_RECALL && step == 3'h5 |=> mem_addr == `NVSQ_CMD_RECALL) else $error("bad recall");
    a_dis_clears: assert property (@(posedge ref_clk) disable iff (reset)
        state == NVSQ_RECOVER && cnt == 8'h01 && step == 3'h5 && cur.op == NVSQ_OP_AS_DIS |=> !autosave_follow)
        else $error("disable not applied");
    a_en_sets: assert property (@(posedge ref_clk) disable iff (reset)
        state == NVSQ_RECOVER && cnt == 8'h01 && step == 3'h5 && cur.op == NVSQ_OP_AS_EN |=> autosave_follow)
        else $error("enable not applied");
    a_no_intervene: assert property (@(posedge ref_clk) disable iff (reset)
        state == NVSQ_RECOVER && is_seq(cur.op) && step < 3'h5 && cnt == 8'h01 |=> state == NVSQ_SETUP && $stable(cur))
        else $error("sequence broken");
    a_chip_select_read: assert property (@(posedge ref_clk) disable iff (reset)
        !mem_ctl.chip_select_n && is_seq(cur.op) |-> mem_ctl.write_enable_n) else $error("sequence not a read");
    c_store: cover property (@(posedge ref_clk) state == NVSQ_WAIT_BUSY && cur.op == NVSQ_OP_STORE);
    c_recall: cover property (@(posedge ref_clk) state == NVSQ_WAIT_BUSY && cur.op == NVSQ_OP_RECALL);
    c_read: cover property (@(posedge ref_clk) rdata_valid);
    c_as_dis: cover property (@(posedge ref_clk) $fell(autosave_follow));

endmodule : nvsq_host

// >>> nvsq_dev_model.sv
// behavioural nvsram device that answers the host controller
`timescale 1ns/1ps
`include "nvsq_defines.svh"
module nvsq_dev_model
    import nvsq_pkg::*;
#(
    parameter int BUSY_CYC = 20 // store and recall time, shortened
) (
    input wire logic ref_clk, // system clock
    input wire logic [`NVSQ_ADDR_W-1:0] mem_addr, // address pins
    input wire nvsq_ctl_s mem_ctl, // strobes, active low
    input wire logic [`NVSQ_DATA_W-1:0] dq_out, // data from host
    output logic [`NVSQ_DATA_W-1:0] dq_in, // data to host
    output logic store_busy_n_in // busy pin level
);
    logic [15:0] sram [0:255];
    logic [15:0] nv [0:255];
    logic [18:0] seq_tab [0:4];
    logic [18:0] a_q;
    logic [15:0] d_q;
    logic we_q;
    logic cs_q;
    logic as_en;
    logic low_supply; // bench hook: supply below threshold
    int step, n_store, n_recall, n_seq_wr, busy_cnt, hold;
    // delivered state: autosave on, array zero
    initial begin
        for (int i = 0; i < 256; i++) begin
            nv[i] = 16'h0000;
            sram[i] = 16'h0000;
        end
        seq_tab = '{`NVSQ_SEQ_A1, `NVSQ_SEQ_A2, `NVSQ_SEQ_A3, `NVSQ_SEQ_A4, `NVSQ_SEQ_A5};
        as_en = 1'b1;
        step = 0;
        n_store = 0;
        n_recall = 0;
        n_seq_wr = 0;
        busy_cnt = 0;
        hold = 0;
        low_supply = 1'b0;
        {cs_q, we_q, store_busy_n_in} = 3'h7;
        dq_in = 16'h0000;
    end
    // only the middle address bits select software modes
    function automatic logic [12:0] key(input logic [18:0] a);
        return a[14:2];
    endfunction : key
    // act once per access, when chip select rises; busy device ignores the bus
    always @(posedge ref_clk) begin
        cs_q <= mem_ctl.chip_select_n;
        if (!mem_ctl.chip_select_n) begin
            a_q <= mem_addr;
            we_q <= mem_ctl.write_enable_n;
            d_q <= dq_out;
        end
        if (busy_cnt > 0) begin
            busy_cnt <= busy_cnt - 1;
            store_busy_n_in <= (busy_cnt == 1);
        end else if (!cs_q && mem_ctl.chip_select_n) begin
            if (!we_q) begin
                // writes are dropped while supply is low
                if (!low_supply) sram[a_q[7:0]] <= d_q;
                n_seq_wr <= n_seq_wr + int'(step != 0);
                step <= 0;
            end else if (step < 5) begin
                step <= (key(a_q) == key(seq_tab[step])) ? step + 1 : int'(key(a_q) == key(seq_tab[0]));
            end else begin
                step <= 0;
                if (key(a_q) == key(`NVSQ_CMD_ASDIS)) as_en <= 1'b0;
                if (key(a_q) == key(`NVSQ_CMD_ASEN)) as_en <= 1'b1;
                // software store runs even without a write
                // low supply blocks the store, so no busy either
                if (key(a_q) == key(`NVSQ_CMD_STORE) && !low_supply) nv <= sram;
                if (key(a_q) == key(`NVSQ_CMD_STORE) && !low_supply) n_store <= n_store + 1;
                // recall overwrites sram, leaves nv untouched
                if (key(a_q) == key(`NVSQ_CMD_RECALL)) sram <= nv;
                if (key(a_q) == key(`NVSQ_CMD_RECALL)) n_recall <= n_recall + 1;
                // busy low for the whole operation
                if (key(a_q) == key(`NVSQ_CMD_RECALL) || (key(a_q) == key(`NVSQ_CMD_STORE) && !low_supply)) begin
                    busy_cnt <= BUSY_CYC;
                    store_busy_n_in <= 1'b0;
                end
            end
        end
    end
    // no data while busy; after hold a changing pattern, never stale data
    always @(posedge ref_clk) begin
        if (!mem_ctl.chip_select_n && mem_ctl.write_enable_n && !mem_ctl.output_enable_n && busy_cnt == 0) begin
            dq_in <= sram[mem_addr[7:0]];
            hold <= 3;
        end else if (hold > 0) hold <= hold - 1;
        else dq_in <= ~dq_in;
    end
endmodule : nvsq_dev_model

// >>> nvsram_soft_sequence_decoder_test.sv
// self-checking bench for the nvsram host controller
`timescale 1ns/1ps
`include "nvsq_defines.svh"
module nvsram_soft_sequence_decoder_test
    import nvsq_pkg::*;
;
    logic ref_clk, reset, req_valid, req_ready, rdata_valid, done, autosave_follow, dq_oe;
    logic store_busy_n_in, store_busy_n_out, store_busy_n_oe;
    nvsq_req_s req;
    nvsq_ctl_s mem_ctl;
    logic [`NVSQ_DATA_W-1:0] rdata, dq_out, dq_in, rd;
    logic [`NVSQ_ADDR_W-1:0] mem_addr;
    int n_errors, cmp_count;
    nvsq_host nvsq_host_i (.ref_clk(ref_clk), .reset(reset), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .done(done),
        .autosave_follow(autosave_follow), .mem_addr(mem_addr), .mem_ctl(mem_ctl), .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in), .store_busy_n_in(store_busy_n_in),
        .store_busy_n_out(store_busy_n_out), .store_busy_n_oe(store_busy_n_oe));
    nvsq_dev_model nvsq_dev_model_i (.ref_clk(ref_clk), .mem_addr(mem_addr), .mem_ctl(mem_ctl),
        .dq_out(dq_out), .dq_in(dq_in), .store_busy_n_in(store_busy_n_in));
    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic give_verdict;
        $display("errors %0d of %0d comparisons", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : give_verdict
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (exp !== got) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    // one request: offer until taken, then wait for done; bounded both ways
    task automatic do_op(input nvsq_op_e op, input logic [18:0] a, input logic [15:0] d);
        int k;
        req <= '{op: op, addr: a, wdata: d, byte_en: 2'h3};
        req_valid <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (req_ready !== 1'b1 && k < 200);
        req_valid <= 1'b0;
        do begin
            @(posedge ref_clk);
            #1;
            k++;
            if (rdata_valid === 1'b1) rd = rdata;
        end while (done !== 1'b1 && k < 600);
        if (k >= 600) check("request timeout", 0, 1);
        if (k >= 600) give_verdict;
        @(posedge ref_clk);
    endtask : do_op
    task automatic t_idle;
        check("idle strobes", 32'h1f, mem_ctl);
        check("dq_oe idle", 0, dq_oe);
        check("autosave after reset", 1, autosave_follow);
        check("busy never driven", 0, store_busy_n_oe);
    endtask : t_idle
    task automatic t_recall_blank;
        do_op(NVSQ_OP_WRITE, 19'h00010, 16'ha5a5);
        do_op(NVSQ_OP_READ, 19'h00010, 16'h0000);
        check("plain read", 32'ha5a5, rd);
        do_op(NVSQ_OP_RECALL, 19'h00000, 16'h0000);
        check("recall count", 1, nvsq_dev_model_i.n_recall);
        do_op(NVSQ_OP_READ, 19'h00010, 16'h0000);
        check("blank nv after recall", 32'h0000, rd);
    endtask : t_recall_blank
    task automatic t_store_recall;
        do_op(NVSQ_OP_WRITE, 19'h00010, 16'h1234);
        do_op(NVSQ_OP_STORE, 19'h00000, 16'h0000);
        check("store count", 1, nvsq_dev_model_i.n_store);
        check("done after busy", 1, store_busy_n_in);
        do_op(NVSQ_OP_WRITE, 19'h00010, 16'hbeef);
        do_op(NVSQ_OP_RECALL, 19'h00000, 16'h0000);
        do_op(NVSQ_OP_READ, 19'h00010, 16'h0000);
        check("restored word", 32'h1234, rd);
        do_op(NVSQ_OP_STORE, 19'h00000, 16'h0000);
        check("store without write", 2, nvsq_dev_model_i.n_store);
    endtask : t_store_recall
    task automatic t_autosave;
        do_op(NVSQ_OP_AS_DIS, 19'h00000, 16'h0000);
        // model acts on the edge after done; let it settle
        @(posedge ref_clk);
        check("host copy off", 0, autosave_follow);
        check("device autosave off", 0, nvsq_dev_model_i.as_en);
        do_op(NVSQ_OP_AS_EN, 19'h00000, 16'h0000);
        @(posedge ref_clk);
        check("host copy on", 1, autosave_follow);
        check("device autosave on", 1, nvsq_dev_model_i.as_en);
        do_op(NVSQ_OP_STORE, 19'h00000, 16'h0000);
        check("store after autosave change", 3, nvsq_dev_model_i.n_store);
        check("writes inside sequences", 0, nvsq_dev_model_i.n_seq_wr);
        check("tracker back at start", 0, nvsq_dev_model_i.step);
    endtask : t_autosave
    task automatic t_low_supply;
        nvsq_dev_model_i.low_supply = 1'b1;
        do_op(NVSQ_OP_WRITE, 19'h00020, 16'h5555);
        do_op(NVSQ_OP_STORE, 19'h00000, 16'h0000);
        nvsq_dev_model_i.low_supply = 1'b0;
        check("store blocked", 3, nvsq_dev_model_i.n_store);
        do_op(NVSQ_OP_READ, 19'h00020, 16'h0000);
        check("write blocked", 32'h0000, rd);
    endtask : t_low_supply
    // main sequence: reset 20 cycles, then each scenario
    initial begin
        n_errors = 0;
        cmp_count = 0;
        reset = 1'b1;
        req_valid = 1'b0;
        req = '0;
        rd = '0;
        repeat (20) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        t_idle;
        // back onto the edge so requests are driven there
        @(posedge ref_clk);
        t_recall_blank;
        t_store_recall;
        t_autosave;
        t_low_supply;
        give_verdict;
    end
endmodule : nvsram_soft_sequence_decoder_test
